// *** hw/dmf_regs.vh ***
`ifndef DMF_REGS_VH
`define DMF_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define DMF_ADDR_W 5
`define DMF_REG_CTRL 5'h00
`define DMF_REG_STATUS 5'h04
`define DMF_REG_TXDOC 5'h08
`define DMF_REG_TXNULL 5'h0C
`define DMF_REG_RXFRM 5'h10

// ****************************************
// Field positions and reset values
// ****************************************
`define DMF_CTRL_TX_EN 0
`define DMF_CTRL_RX_EN 1
`define DMF_CTRL_RST 2'h0
`define DMF_ST_LOCKED 0
`define DMF_ST_UNDERRUN 1
`define DMF_ST_ABORT 2
`define DMF_ST_CC_LO 4

// ****************************************
// Packet constants
// ****************************************
`define DMF_SYNC_BYTE 8'h47
`define DMF_STUFF_BYTE 8'hFF
`define DMF_DOC_PID 13'h1FFE
`define DMF_NULL_PID 13'h1FFF
`define DMF_AFC_PAYLOAD 2'h1
`define DMF_PKT_LEN 8'd188
`define DMF_HDR_LEN 8'd4
`define DMF_PAY_FULL 16'd184
`define DMF_ACQ_COUNT 3'd5
`define DMF_LOSS_COUNT 4'd9
`define DMF_BYTE_DIV 16

`endif

// *** hw/dmf_rx_sync.v ***
`timescale 1ns/1ps
`include "dmf_regs.vh"

module dmf_rx_sync (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Byte stream from the physical layer
   input wire i_enable,
   input wire i_byte_valid,
   input wire [7:0] i_byte_data,
   // Alignment state
   output wire o_locked,
   output reg [7:0] o_pos,
   output reg o_pos_valid,
   output reg [7:0] o_data
);

   // ****************************************
   // Alignment state machine
   // ****************************************
   localparam [2:0] S_HUNT = 3'b001;
   localparam [2:0] S_CHECK = 3'b010;
   localparam [2:0] S_LOCK = 3'b100;

   reg [2:0] state_q;
   reg [7:0] pos_q;
   reg [2:0] good_q;
   reg [3:0] bad_q;
   wire boundary;
   wire sync_ok;

   assign boundary = (pos_q == `DMF_PKT_LEN - 8'd1);
   assign sync_ok = (i_byte_data == `DMF_SYNC_BYTE);
   assign o_locked = state_q[2];

   always @(posedge i_core_clk) begin
      if (i_sys_rst || !i_enable) begin
         state_q <= S_HUNT;
         pos_q <= 8'h00;
         good_q <= 3'h0;
         bad_q <= 4'h0;
         o_pos <= 8'h00;
         o_pos_valid <= 1'b0;
         o_data <= 8'h00;
      end else begin
         o_pos_valid <= 1'b0;
         if (i_byte_valid) begin
            o_data <= i_byte_data;
            case (state_q)
               S_HUNT: begin
                  if (sync_ok) begin
                     state_q <= S_CHECK;
                     good_q <= 3'h1;
                     pos_q <= 8'h00;
                  end
               end
               S_CHECK: begin
                  if (boundary) begin
                     pos_q <= 8'h00;
                     if (sync_ok) begin
                        good_q <= good_q + 3'h1;
                        if (good_q + 3'h1 == `DMF_ACQ_COUNT) begin
                           state_q <= S_LOCK;
                           bad_q <= 4'h0;
                           o_pos <= 8'h00;
                           o_pos_valid <= 1'b1;
                        end
                     end else begin
                        state_q <= S_HUNT;
                     end
                  end else begin
                     pos_q <= pos_q + 8'h01;
                  end
               end
               S_LOCK: begin
                  if (boundary) begin
                     pos_q <= 8'h00;
                     if (sync_ok) begin
                        bad_q <= 4'h0;
                        o_pos <= 8'h00;
                        o_pos_valid <= 1'b1;
                     end else if (bad_q + 4'h1 == `DMF_LOSS_COUNT) begin
                        state_q <= S_HUNT;
                     end else begin
                        bad_q <= bad_q + 4'h1;
                        o_pos <= 8'h00;
                        o_pos_valid <= 1'b1;
                     end
                  end else begin
                     pos_q <= pos_q + 8'h01;
                     o_pos <= pos_q + 8'h01;
                     o_pos_valid <= 1'b1;
                  end
               end
               default: state_q <= S_HUNT;
            endcase
         end
      end
   end

endmodule

// *** hw/dmf_rx_extract.v ***
`timescale 1ns/1ps
`include "dmf_regs.vh"

module dmf_rx_extract (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Aligned bytes
   input wire i_locked,
   input wire [7:0] i_pos,
   input wire i_pos_valid,
   input wire [7:0] i_data,
   // MAC side
   input wire i_frame_done,
   output reg o_mac_valid,
   output reg [7:0] o_mac_data,
   output reg o_mac_sof,
   output reg o_abort
);

   // ****************************************
   // Extraction state machine
   // ****************************************
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_HUNT = 3'b010;
   localparam [2:0] S_FRAME = 3'b100;

   reg [2:0] state_q;
   reg payload_start_flag_q;
   reg [4:0] pid_hi_q;
   reg doc_q;
   reg [7:0] skip_q;
   reg skipping_q;

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_q <= S_IDLE;
         payload_start_flag_q <= 1'b0;
         pid_hi_q <= 5'h00;
         doc_q <= 1'b0;
         skip_q <= 8'h00;
         skipping_q <= 1'b0;
         o_mac_valid <= 1'b0;
         o_mac_data <= 8'h00;
         o_mac_sof <= 1'b0;
         o_abort <= 1'b0;
      end else begin
         o_mac_valid <= 1'b0;
         o_mac_sof <= 1'b0;
         o_abort <= 1'b0;
         if (!i_locked) begin
            o_abort <= state_q[2];
            state_q <= S_IDLE;
         end else begin
            if (state_q[0]) begin
               state_q <= S_HUNT;
            end
            if (state_q[2] && i_frame_done) begin
               state_q <= S_HUNT;
            end
            if (i_pos_valid) begin
               case (i_pos)
                  8'd0: doc_q <= 1'b0;
                  8'd1: begin
                     payload_start_flag_q <= i_data[6];
                     pid_hi_q <= i_data[4:0];
                  end
                  8'd2: doc_q <= ({pid_hi_q, i_data} == `DMF_DOC_PID)
                     && !(state_q[0]);
                  8'd3: skipping_q <= 1'b0;
                  8'd4: begin
                     if (doc_q && payload_start_flag_q) begin
                        skip_q <= i_data;
                        skipping_q <= (i_data != 8'h00);
                        if (i_data == 8'h00 && state_q[2]) begin
                           o_abort <= 1'b1;
                           state_q <= S_HUNT;
                        end
                     end else if (doc_q && state_q[2]) begin
                        o_mac_valid <= 1'b1;
                        o_mac_data <= i_data;
                     end
                  end
                  default: begin
                     if (!doc_q) begin
                        skipping_q <= skipping_q;
                     end else if (skipping_q) begin
                        // Tail of the previous frame is still delivered
                        skip_q <= skip_q - 8'h01;
                        if (skip_q == 8'h01) begin
                           skipping_q <= 1'b0;
                        end
                        if (state_q[2]) begin
                           o_mac_valid <= 1'b1;
                           o_mac_data <= i_data;
                        end
                        if (skip_q == 8'h01 && state_q[2] && !i_frame_done)
                        begin
                           state_q <= S_HUNT;
                        end
                     end else if (state_q[2] && !i_frame_done) begin
                        o_mac_valid <= 1'b1;
                        o_mac_data <= i_data;
                     end else if (i_data != `DMF_STUFF_BYTE) begin
                        state_q <= S_FRAME;
                        o_mac_valid <= 1'b1;
                        o_mac_sof <= 1'b1;
                        o_mac_data <= i_data;
                     end
                  end
               endcase
            end
         end
      end
   end

endmodule

// *** hw/dmf_framer.v ***
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "dmf_regs.vh"

// Operation
// - Payload-start flag set means first payload byte is the pointer byte
// - Gaps between MAC frames in a payload are filled with 0xFF bytes
// - A frame control byte is never 0xFF; receiver treats 0xFF as filler
// - Pointer byte is packet byte five, right after the four header bytes
// - Receiver skips pointer-value bytes after the pointer before hunting
// - Framer sets flag and pointer whenever a frame could begin in packet
// - Pointer indexes first frame start or a filler byte before it
// - Frames start anywhere, span packets, several share one packet
// - Pointer zero means hunt from the byte right after the pointer
// - With a frame tail at packet start, pointer indexes byte after tail
// - Send null packets instead of cable-data packets holding only filler
// - Consecutive frames go back to back or with filler between
// - Flag clear: 184 continuing bytes; with pointer at most 183 bytes
// - Framer exposes the exact transfer slot for timestamp insertion
// - Alignment acquired after five correct sync bytes 188 bytes apart
// - Alignment lost after nine bad sync bytes, then search restarts
// - Fixed framing latency keeps MAC timing relationships intact
// - Each packet opens with sync byte 0x47, checked every 188 bytes
// - Cable data uses identifier 0x1FFE; only those packets are extracted
// - Adaptation field control is 01, payload only
// - Four-bit header counter increments per cable-data packet sent

module dmf_framer #(
   parameter BYTE_DIV = `DMF_BYTE_DIV
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Register port
   input wire [`DMF_ADDR_W-1:0] i_addr,
   input wire [31:0] i_wr_data,
   input wire i_wr_en,
   input wire i_rd_en,
   output reg [31:0] o_rd_data,
   // MAC transmit frames
   input wire i_mac_valid,
   input wire [7:0] i_mac_data,
   input wire i_mac_sof,
   input wire [15:0] i_mac_len,
   output wire o_mac_ready,
   // Transport stream out
   output reg o_ts_valid,
   output reg [7:0] o_ts_data,
   output reg o_ts_sop,
   // Transport stream in
   input wire i_rx_valid,
   input wire [7:0] i_rx_data,
   // MAC receive frames
   input wire i_rx_frame_done,
   output wire o_rx_mac_valid,
   output wire [7:0] o_rx_mac_data,
   output wire o_rx_mac_sof,
   output wire o_rx_locked
);

   // ****************************************
   // Helpers
   // ****************************************
   function [7:0] hdr_byte;
      input [1:0] idx;
      input start;
      input [12:0] pid;
      input [3:0] cc;
      begin
         case (idx)
            2'd0: hdr_byte = `DMF_SYNC_BYTE;
            2'd1: hdr_byte = {1'b0, start, 1'b0, pid[12:8]};
            2'd2: hdr_byte = pid[7:0];
            default: hdr_byte = {2'b00, `DMF_AFC_PAYLOAD, cc};
         endcase
      end
   endfunction

   // ****************************************
   // Byte slot divider
   // ****************************************
   localparam DIV_W = 16;
   reg [DIV_W-1:0] div_q;
   wire slot;

   assign slot = (div_q == BYTE_DIV[DIV_W-1:0] - 16'd1);

   always @(posedge i_core_clk) begin
      if (i_sys_rst || slot) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   reg [1:0] ctrl_q;
   reg underrun_q;
   reg abort_st_q;
   reg [31:0] txdoc_q;
   reg [31:0] txnull_q;
   reg [31:0] rxfrm_q;
   reg [3:0] cc_q;
   reg underrun_ev;
   wire rx_abort;
   wire wr_status;

   assign wr_status = i_wr_en && (i_addr == `DMF_REG_STATUS);

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctrl_q <= `DMF_CTRL_RST;
         underrun_q <= 1'b0;
         abort_st_q <= 1'b0;
         rxfrm_q <= 32'h0000_0000;
         o_rd_data <= 32'h0000_0000;
      end else begin
         if (i_wr_en && i_addr == `DMF_REG_CTRL) begin
            ctrl_q <= i_wr_data[1:0];
         end
         // Set wins over write-one-to-clear
         if (underrun_ev) begin
            underrun_q <= 1'b1;
         end else if (wr_status && i_wr_data[`DMF_ST_UNDERRUN]) begin
            underrun_q <= 1'b0;
         end
         if (rx_abort) begin
            abort_st_q <= 1'b1;
         end else if (wr_status && i_wr_data[`DMF_ST_ABORT]) begin
            abort_st_q <= 1'b0;
         end
         if (o_rx_mac_valid && o_rx_mac_sof) begin
            rxfrm_q <= rxfrm_q + 32'h0000_0001;
         end
         o_rd_data <= 32'h0000_0000;
         if (i_rd_en) begin
            case (i_addr)
               `DMF_REG_CTRL: o_rd_data <= {30'h0, ctrl_q};
               `DMF_REG_STATUS: o_rd_data <= {24'h0, cc_q, 1'b0,
                  abort_st_q, underrun_q, o_rx_locked};
               `DMF_REG_TXDOC: o_rd_data <= txdoc_q;
               `DMF_REG_TXNULL: o_rd_data <= txnull_q;
               `DMF_REG_RXFRM: o_rd_data <= rxfrm_q;
               default: o_rd_data <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************
   // Transmit framer
   // ****************************************
   localparam [3:0] T_IDLE = 4'b0001;
   localparam [3:0] T_HDR = 4'b0010;
   localparam [3:0] T_PTR = 4'b0100;
   localparam [3:0] T_PAY = 4'b1000;

   reg [3:0] tstate_q;
   reg [7:0] pos_q;
   reg doc_q;
   reg payload_start_flag_q;
   reg [7:0] ptr_q;
   reg [15:0] rem_q;
   wire pkt_last;
   wire take_sof;
   wire in_frame;
   wire start_doc;

   assign pkt_last = (pos_q == `DMF_PKT_LEN - 8'd1);
   assign in_frame = (rem_q != 16'h0000);
   assign take_sof = i_mac_valid && i_mac_sof;
   assign start_doc = in_frame || i_mac_valid;
   // Ready marks the exact slot a byte leaves, one cycle before the wire
   assign o_mac_ready = slot && tstate_q[3] && doc_q
      && (in_frame || i_mac_sof);

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         tstate_q <= T_IDLE;
         pos_q <= 8'h00;
         doc_q <= 1'b0;
         payload_start_flag_q <= 1'b0;
         ptr_q <= 8'h00;
         rem_q <= 16'h0000;
         cc_q <= 4'h0;
         txdoc_q <= 32'h0000_0000;
         txnull_q <= 32'h0000_0000;
         underrun_ev <= 1'b0;
         o_ts_valid <= 1'b0;
         o_ts_data <= 8'h00;
         o_ts_sop <= 1'b0;
      end else begin
         o_ts_valid <= 1'b0;
         o_ts_sop <= 1'b0;
         underrun_ev <= 1'b0;
         if (slot) begin
            case (tstate_q)
               T_IDLE: begin
                  if (ctrl_q[`DMF_CTRL_TX_EN]) begin
                     doc_q <= start_doc;
                     // Long tail fills the packet; no frame can begin
                     payload_start_flag_q <=
                        rem_q < `DMF_PAY_FULL;
                     ptr_q <= rem_q[7:0];
                     pos_q <= 8'h01;
                     tstate_q <= T_HDR;
                     o_ts_valid <= 1'b1;
                     o_ts_sop <= 1'b1;
                     o_ts_data <= `DMF_SYNC_BYTE;
                     if (start_doc) begin
                        txdoc_q <= txdoc_q + 32'h0000_0001;
                     end else begin
                        txnull_q <= txnull_q + 32'h0000_0001;
                     end
                  end
               end
               T_HDR: begin
                  o_ts_valid <= 1'b1;
                  o_ts_data <= hdr_byte(pos_q[1:0],
                     doc_q && payload_start_flag_q,
                     doc_q ? `DMF_DOC_PID : `DMF_NULL_PID, cc_q);
                  pos_q <= pos_q + 8'h01;
                  if (pos_q == `DMF_HDR_LEN - 8'd1) begin
                     if (doc_q) begin
                        cc_q <= cc_q + 4'h1;
                     end
                     tstate_q <= (doc_q && payload_start_flag_q) ?
                        T_PTR : T_PAY;
                  end
               end
               T_PTR: begin
                  o_ts_valid <= 1'b1;
                  o_ts_data <= ptr_q;
                  pos_q <= pos_q + 8'h01;
                  tstate_q <= T_PAY;
               end
               T_PAY: begin
                  o_ts_valid <= 1'b1;
                  o_ts_data <= `DMF_STUFF_BYTE;
                  if (doc_q && in_frame) begin
                     rem_q <= rem_q - 16'h0001;
                     if (i_mac_valid) begin
                        o_ts_data <= i_mac_data;
                     end else begin
                        underrun_ev <= 1'b1;
                     end
                  end else if (doc_q && take_sof) begin
                     // New frame right after the last one or after filler
                     o_ts_data <= i_mac_data;
                     rem_q <= (i_mac_len == 16'h0000) ? 16'h0000 :
                        i_mac_len - 16'h0001;
                  end
                  if (pkt_last) begin
                     pos_q <= 8'h00;
                     tstate_q <= T_IDLE;
                  end else begin
                     pos_q <= pos_q + 8'h01;
                  end
               end
               default: tstate_q <= T_IDLE;
            endcase
         end
      end
   end

   // ****************************************
   // Receive path
   // ****************************************
   wire [7:0] sync_pos;
   wire sync_pos_valid;
   wire [7:0] sync_data;

   dmf_rx_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_enable(ctrl_q[`DMF_CTRL_RX_EN]),
      .i_byte_valid(i_rx_valid),
      .i_byte_data(i_rx_data),
      .o_locked(o_rx_locked),
      .o_pos(sync_pos),
      .o_pos_valid(sync_pos_valid),
      .o_data(sync_data)
   );

   dmf_rx_extract u_extract (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_locked(o_rx_locked),
      .i_pos(sync_pos),
      .i_pos_valid(sync_pos_valid),
      .i_data(sync_data),
      .i_frame_done(i_rx_frame_done),
      .o_mac_valid(o_rx_mac_valid),
      .o_mac_data(o_rx_mac_data),
      .o_mac_sof(o_rx_mac_sof),
      .o_abort(rx_abort)
   );

endmodule

// *** test/dmf_framer_assertions.sv ***
`timescale 1ns/1ps
`include "dmf_regs.vh"

// ********
// Framer port checker
// ********
module dmf_framer_chk (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Register port
   input wire [`DMF_ADDR_W-1:0] i_addr,
   input wire i_rd_en,
   input wire [31:0] o_rd_data,
   // MAC transmit
   input wire i_mac_valid,
   input wire [7:0] i_mac_data,
   input wire o_mac_ready,
   // Transport streams
   input wire o_ts_valid,
   input wire [7:0] o_ts_data,
   input wire o_ts_sop,
   input wire i_rx_valid,
   input wire [7:0] i_rx_data,
   // MAC receive
   input wire o_rx_mac_valid,
   input wire [7:0] o_rx_mac_data,
   input wire o_rx_mac_sof,
   input wire o_rx_locked
);
   reg [7:0] cnt_q;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_q <= 8'h00;
      end else if (o_ts_valid) begin
         cnt_q <= o_ts_sop ? 8'h01 : cnt_q + 8'h01;
      end
   end
   a_sync_value:
   assert property (o_ts_sop |-> o_ts_valid && o_ts_data == 8'h47)
   else $error("bad sync byte");
   a_packet_len:
   assert property (o_ts_sop && cnt_q != 8'h00 |-> cnt_q == 8'hBC)
   else $error("bad packet length");
   a_pid_high:
   assert property (o_ts_valid && !o_ts_sop && cnt_q == 8'h01 |->
      !o_ts_data[7] && o_ts_data[5:0] == 6'h1F)
   else $error("bad header byte");
   a_afc_payload:
   assert property (o_ts_valid && cnt_q == 8'h03 |-> o_ts_data[7:4] == 4'h1)
   else $error("bad adaptation control");
   a_ready_payload:
   assert property (o_mac_ready |-> cnt_q >= 8'h04 && cnt_q <= 8'hBB)
   else $error("byte taken outside payload");
   a_ready_to_wire:
   assert property (o_mac_ready && i_mac_valid |=>
      o_ts_valid && o_ts_data == $past(i_mac_data))
   else $error("taken byte not sent");
   a_status_lock:
   assert property (i_rd_en && i_addr == `DMF_REG_STATUS |=>
      o_rd_data[0] == $past(o_rx_locked))
   else $error("bad status lock bit");
   a_rx_gated:
   assert property (o_rx_mac_valid |-> o_rx_locked)
   else $error("delivery unaligned");
   a_rx_latency:
   assert property (o_rx_mac_valid |-> $past(i_rx_valid, 2) &&
      o_rx_mac_data == $past(i_rx_data, 2))
   else $error("delivered byte wrong");
   a_sof_not_fill:
   assert property (o_rx_mac_valid && o_rx_mac_sof |->
      o_rx_mac_data != 8'hFF)
   else $error("filler as frame start");
endmodule

// *** test/dmf_mac_src.sv ***
`timescale 1ns/1ps

// ********
// MAC transmit source
// ********
module dmf_mac_src (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Framer handshake
   input wire i_ready,
   output reg o_valid,
   output reg [7:0] o_data,
   output reg o_sof,
   output reg [15:0] o_len
);
   int len_q[$], len, k;
   reg [7:0] fid;
   task push(input int n);
      len_q.push_back(n);
   endtask
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         len = 0;
         k = 0;
         fid = 8'h00;
      end else if (i_ready && o_valid) begin
         k = k + 1;
      end
      // Next frame offered at once
      if (!i_sys_rst && k >= len && len_q.size() > 0) begin
         len = len_q.pop_front();
         k = 0;
         fid = fid + 8'h01;
      end
      o_valid <= k < len;
      o_sof <= k == 0 && k < len;
      o_len <= len[15:0];
      // First byte never the filler value
      if (k < len) begin
         o_data <= k == 0 ? {4'h2, fid[3:0]} : k[7:0] + fid;
      end else begin
         o_data <= ~o_data;
      end
   end
endmodule

// *** test/dmf_framer_bench.sv ***
`timescale 1ns/1ps
`include "dmf_regs.vh"

// ********
// Framer bench
// ********
module dmf_framer_bench;
   localparam int DIV = 6;
   typedef struct {int a, b, np;} dmf_row_t;
   dmf_row_t rows [8] = '{'{1, 0, 1}, '{183, 0, 1}, '{184, 0, 2},
      '{366, 0, 2}, '{367, 0, 2}, '{368, 0, 3}, '{10, 20, 1}, '{190, 30, 2}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0, d;
   logic wr_en = 1'b0, rd_en = 1'b0, rx_valid = 1'b0, rx_done = 1'b0;
   logic [7:0] rx_data = 8'h00, bad = 8'h00;
   wire [31:0] rd_data;
   wire mac_valid, mac_sof, mac_ready, ts_valid, ts_sop;
   wire rx_mac_valid, rx_mac_sof, rx_locked;
   wire [7:0] mac_data, ts_data, rx_mac_data;
   wire [15:0] mac_len;
   logic [7:0] pk [188];
   logic [3:0] cc = 4'h0;
   logic [7:0] fid = 8'h00, nf = 8'h00, rf;
   int rem = 0, k = 0, rk = 0, rl = 0, ndoc = 0, nrx = 0, np, ns, i;
   int bq[$], pend[$], rxq[$];
   bit rx_on = 1'b1;
   int n_mismatch = 0, comparisons = 0;

   always #4 clk = ~clk;

   dmf_framer #(.BYTE_DIV(DIV)) dmf_framer_inst (.i_core_clk(clk),
      .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .o_rd_data(rd_data), .i_mac_valid(mac_valid),
      .i_mac_data(mac_data), .i_mac_sof(mac_sof), .i_mac_len(mac_len),
      .o_mac_ready(mac_ready), .o_ts_valid(ts_valid), .o_ts_data(ts_data),
      .o_ts_sop(ts_sop), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .i_rx_frame_done(rx_done), .o_rx_mac_valid(rx_mac_valid),
      .o_rx_mac_data(rx_mac_data), .o_rx_mac_sof(rx_mac_sof),
      .o_rx_locked(rx_locked));
   dmf_mac_src dmf_mac_src_inst (.i_core_clk(clk), .i_sys_rst(rst),
      .i_ready(mac_ready), .o_valid(mac_valid), .o_data(mac_data),
      .o_sof(mac_sof), .o_len(mac_len));

   // Loopback; sync bytes corrupted on demand
   always @(posedge clk) begin
      rx_valid <= ts_valid;
      rx_data <= ts_sop ? ts_data ^ bad : ts_data;
   end

   function automatic logic [7:0] fb(input logic [7:0] f, input int n);
      return n == 0 ? {4'h2, f[3:0]} : n[7:0] + f;
   endfunction

   task automatic chk(string nm, logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task final_report;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task give_up;
      n_mismatch++;
      final_report;
   endtask

   task count_sops(logic v, int lim);
      ns = 0;
      for (i = 0; rx_locked !== v; i++) begin
         if (i > lim) give_up;
         @(posedge clk);
         if (ts_sop) ns++;
      end
   endtask

   task wr(logic [4:0] a, logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task rd(logic [4:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   // Capture a packet; queue frames once its sync byte passes
   task automatic get_pkt;
      int t = 0, n = 0;
      while (n < 188) begin
         @(posedge clk);
         t++;
         if (t > 2400) give_up;
         if (ts_valid && (n > 0 || ts_sop)) begin
            pk[n] = ts_data;
            n++;
            if (n == 1) begin
               foreach (pend[j]) begin
                  nf++;
                  bq.push_back(pend[j]);
                  dmf_mac_src_inst.push(pend[j]);
                  if (rx_on) rxq.push_back(nf * 65536 + pend[j]);
               end
               pend.delete();
            end
         end
      end
   endtask

   task chk_pkt;
      int p;
      bit nul;
      nul = rem == 0 && bq.size() == 0;
      get_pkt;
      chk("sync", pk[0], 8'h47);
      if (nul) begin
         chk("null_pid", {pk[1][4:0], pk[2]}, 13'h1FFF);
         for (p = 4; p < 188; p++) chk("null", pk[p], 8'hFF);
      end else begin
         ndoc++;
         chk("pid", {pk[1][4:0], pk[2]}, 13'h1FFE);
         chk("afc", pk[3][7:4], 4'h1);
         chk("start_flag", pk[1][6], rem < 184);
         chk("cc", pk[3][3:0], cc);
         cc++;
         p = 4;
         if (rem < 184) begin
            chk("ptr", pk[4], rem);
            p = 5;
         end
         for (; p < 188; p++) begin
            if (rem == 0 && bq.size() > 0) begin
               rem = bq.pop_front();
               fid++;
               k = 0;
            end
            chk("payload", pk[p], rem > 0 ? fb(fid, k) : 8'hFF);
            if (rem > 0) begin
               k++;
               rem--;
            end
         end
      end
   endtask

   // Check delivered frames; end each after its length
   always @(posedge clk) begin
      rx_done <= 1'b0;
      if (rx_mac_valid === 1'b1) begin
         if (rk == 0) begin
            chk("rx_frame", rxq.size() > 0, 1'b1);
            rl = rxq.size() > 0 ? rxq.pop_front() : 0;
            rf = rl / 65536;
            rl = rl % 65536;
         end
         chk("rx_data", rx_mac_data, fb(rf, rk));
         chk("rx_sof", rx_mac_sof, rk == 0);
         rk++;
         if (rk >= rl) begin
            rk = 0;
            nrx++;
            rx_done <= 1'b1;
         end
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("ts_valid", ts_valid, 1'b0);
      chk("locked", rx_locked, 1'b0);
      rd(`DMF_REG_CTRL);
      chk("ctrl", d, 32'h0);
      rd(5'h14);
      chk("unmapped", d, 32'h0);
      wr(`DMF_REG_CTRL, 32'h3);
      rd(`DMF_REG_CTRL);
      chk("ctrl", d, 32'h3);
      count_sops(1'b1, 9000);
      chk("lock_syncs", ns, 5);
      rd(`DMF_REG_STATUS);
      chk("status_lock", d[0], 1'b1);
      foreach (rows[r]) begin
         pend.push_back(rows[r].a);
         if (rows[r].b > 0) pend.push_back(rows[r].b);
         chk_pkt;
         for (np = 0; np < 8 && (rem > 0 || bq.size() > 0); np++) chk_pkt;
         chk("packets", np, rows[r].np);
      end
      rd(`DMF_REG_TXDOC);
      chk("doc_count", d, ndoc);
      rd(`DMF_REG_RXFRM);
      chk("rx_count", d, nrx);
      bad <= 8'h01;
      count_sops(1'b0, 15000);
      chk("loss_syncs", ns, 9);
      rd(`DMF_REG_STATUS);
      chk("status_lock", d[0], 1'b0);
      rx_on = 1'b0;
      pend.push_back(40);
      repeat (3) chk_pkt;
      rd(`DMF_REG_RXFRM);
      chk("rx_count", d, nrx);
      final_report;
   end
endmodule

bind dmf_framer dmf_framer_chk dmf_framer_chk_inst (.i_core_clk, .i_sys_rst,
   .i_addr, .i_rd_en, .o_rd_data, .i_mac_valid, .i_mac_data, .o_mac_ready,
   .o_ts_valid, .o_ts_data, .o_ts_sop, .i_rx_valid, .i_rx_data,
   .o_rx_mac_valid, .o_rx_mac_data, .o_rx_mac_sof, .o_rx_locked);
